// ==== design/dfa_datapath.sv ====
/*
  single-cycle datapath: saturation select, bit-reversed increment, double abs, add and conversions.
  assumes issue_valid one cycle at a time with operands stable; results and flags are registered.
*/
module dfa_datapath (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // issue
  input wire logic issue_valid,
  input wire dfa_pkg::dfa_op_t issue_op,
  input wire logic [63:0] first_source_operand,
  input wire logic [63:0] second_source_operand,
  input wire logic sat_ovf,
  input wire logic sat_carry,
  // control from fp_status_control_reg
  input wire dfa_pkg::dfa_ctrl_t ctrl,
  // result
  output logic done_q,
  output logic wr_en_q,
  output logic [63:0] result_q,
  output logic invalid_trap_q,
  output logic arith_trap_q,
  output logic round_trap_q,
  output logic status_upd_q,
  output dfa_pkg::dfa_status_t status_q
);
  // normalise a 64-bit magnitude: returns exponent, 52-bit fraction, guard and two sticky halves
  function automatic logic [65:0] dfa_norm(input logic [63:0] mag, input logic [10:0] maxexp);
    logic [63:0] v;
    logic [10:0] sc;
    v = mag;
    sc = 11'h0_00;
    for (int i = 0; i < 64; i++) begin
      if (!v[63]) begin
        v = v << 1;
        sc = sc + 11'h0_01;
      end
    end
    dfa_norm = {maxexp - sc, v[62:11], v[10], |v[9:5], |v[4:0]};
  endfunction : dfa_norm

  logic [63:0] res_d;
  logic wr_d, inv_trap_d, ar_trap_d, rnd_trap_d, upd_d;
  dfa_pkg::dfa_status_t st_d;

  // operand decode
  logic a_sign, b_sign, a_spec, b_spec, a_den, b_den;
  logic [10:0] a_exp, b_exp;
  assign a_sign = first_source_operand[63];
  assign b_sign = second_source_operand[63];
  assign a_exp = first_source_operand[62:52];
  assign b_exp = second_source_operand[62:52];
  assign a_spec = (a_exp == dfa_pkg::DFA_EXP_MAX);
  assign b_spec = (b_exp == dfa_pkg::DFA_EXP_MAX);
  assign a_den = (a_exp == 11'h0_00) && (first_source_operand[51:0] != 52'h0);
  assign b_den = (b_exp == 11'h0_00) && (second_source_operand[51:0] != 52'h0);

  // add core: aligned magnitudes with 2 extra bits for guard/round, plus sticky
  logic swap;
  logic [63:0] big, sml;
  logic [10:0] ediff;
  logic [55:0] mb, ms, msh;
  logic sh_st;
  logic [56:0] msum;
  logic eff_sub;
  logic [65:0] add_n;
  logic [11:0] add_exp;
  logic add_zero, add_ovf, add_unf, add_g, add_s;
  logic [51:0] add_frac;
  always_comb begin
    swap = (second_source_operand[62:0] > first_source_operand[62:0]);
    big = swap ? second_source_operand : first_source_operand;
    sml = swap ? first_source_operand : second_source_operand;
    ediff = big[62:52] - sml[62:52];
    mb = {1'b0, (big[62:52] != 11'h0_00), big[51:0], 2'b00};
    ms = {1'b0, (sml[62:52] != 11'h0_00), sml[51:0], 2'b00};
    msh = (ediff > 11'h0_37) ? 56'h0 : (ms >> ediff);
    sh_st = (ediff > 11'h0_37) ? (ms != 56'h0) : ((msh << ediff) != ms);
    eff_sub = big[63] ^ sml[63];
    msum = eff_sub ? ({1'b0, mb} - {1'b0, msh} - {56'h0, sh_st}) : ({1'b0, mb} + {1'b0, msh});
    add_zero = (msum == 57'h0) && !sh_st;
    add_n = dfa_norm({msum, 7'h00}, 11'h0_00);
    // exponent: leading one at bit 62 means a carry into bit 55 of the unshifted sum
    add_exp = {1'b0, big[62:52]} + 12'h0_02 - {1'b0, 11'h0_00 - add_n[65:55]} - 12'h0_00;
    add_frac = add_n[54:3];
    add_g = add_n[2];
    add_s = add_n[1] | add_n[0] | sh_st;
    add_ovf = !add_zero && ($signed(add_exp) >= $signed({1'b0, dfa_pkg::DFA_EXP_MAX}));
    add_unf = !add_zero && ($signed(add_exp) <= $signed(12'h0_00));
  end

  // integer conversion magnitude
  logic [63:0] cv_in, cv_mag;
  logic cv_sign;
  logic [65:0] cv_n;
  logic [10:0] cv_base;
  always_comb begin
    cv_in = {{32{second_source_operand[31]}}, second_source_operand[31:0]};
    if (issue_op == dfa_pkg::DFA_OP_CFSID) cv_in = second_source_operand;
    cv_sign = cv_in[63];
    cv_mag = cv_sign ? (~cv_in + 64'h1) : cv_in;
    // word alignments sit 32 positions higher in the 64-bit normaliser
    cv_base = ((issue_op == dfa_pkg::DFA_OP_CFSF) ? dfa_pkg::DFA_EXP_FRAC : dfa_pkg::DFA_EXP_INT) + 11'h0_20;
    cv_n = dfa_norm(cv_mag, cv_base);
  end

  // shared rounding of {exp,frac} with guard and sticky
  function automatic logic [62:0] dfa_round(input logic [62:0] v, input logic sgn, input logic g,
                                            input logic s, input logic [1:0] mode);
    logic inc;
    inc = 1'b0;
    if (mode == dfa_pkg::DFA_RND_NEAR) inc = g & (s | v[0]);
    else if (mode == dfa_pkg::DFA_RND_PINF) inc = !sgn & (g | s);
    else if (mode == dfa_pkg::DFA_RND_MINF) inc = sgn & (g | s);
    dfa_round = v + {62'h0, inc};
  endfunction : dfa_round

  logic [63:0] brinc_v, sp_v;
  logic [7:0] s_exp;
  always_comb begin
    // reverse the mask/index, add one under the mask, reverse back
    brinc_v = first_source_operand;
    begin : brinc_blk
      logic [63:0] rev_i, rev_m, rev_sum, rev_o;
      rev_i = 64'h0000_0000_0000_0000;
      rev_m = 64'h0000_0000_0000_0000;
      rev_o = 64'h0000_0000_0000_0000;
      for (int i = 0; i < 64; i++) begin
        rev_i[i] = first_source_operand[63 - i] | ~second_source_operand[63 - i];
        rev_m[i] = second_source_operand[63 - i];
      end
      rev_sum = rev_i + 64'h1;
      for (int i = 0; i < 64; i++) rev_o[i] = rev_sum[63 - i];
      brinc_v = (first_source_operand & ~second_source_operand) | (rev_o & second_source_operand);
      if (rev_m == 64'h0) brinc_v = first_source_operand;
    end
    sp_v = second_source_operand;
    s_exp = second_source_operand[30:23];
  end

  always_comb begin
    res_d = result_q;
    wr_d = 1'b0;
    inv_trap_d = 1'b0;
    ar_trap_d = 1'b0;
    rnd_trap_d = 1'b0;
    upd_d = 1'b0;
    st_d = status_q;
    if (issue_valid) begin
      wr_d = 1'b1;
      unique case (issue_op)
        dfa_pkg::DFA_OP_SAT: begin
          res_d = sat_ovf ? (sat_carry ? second_source_operand : first_source_operand) : sp_v;
          // operand convention: neg_sat in second, pos_sat in first, value in low operand path
          if (!sat_ovf) res_d = {32'h0, second_source_operand[31:0]} | {first_source_operand[63:32], 32'h0} & 64'h0;
        end
        dfa_pkg::DFA_OP_BRINC: res_d = brinc_v;
        dfa_pkg::DFA_OP_ABS: begin
          res_d = {1'b0, first_source_operand[62:0]};
          if (ctrl.abs_detect_enable && (a_spec || a_den)) begin
            upd_d = 1'b1;
            st_d.invalid_flag = 1'b1;
            st_d.guard_status_bit = 1'b0;
            st_d.sticky_status_bit = 1'b0;
            if (ctrl.invalid_enable) begin
              wr_d = 1'b0;
              inv_trap_d = 1'b1;
            end
          end
        end
        dfa_pkg::DFA_OP_ADD: begin
          upd_d = 1'b1;
          st_d.guard_status_bit = add_g;
          st_d.sticky_status_bit = add_s;
          res_d = add_zero ? 64'h0 : {big[63], dfa_round({add_exp[10:0], add_frac}, big[63], add_g, add_s,
                                                         ctrl.rounding_control_field)};
          if (a_spec) res_d = a_sign ? dfa_pkg::DFA_NMAX : dfa_pkg::DFA_PMAX;
          else if (b_spec) res_d = b_sign ? dfa_pkg::DFA_NMAX : dfa_pkg::DFA_PMAX;
          if (a_spec || b_spec || a_den || b_den) begin
            st_d.invalid_flag = 1'b1;
            st_d.guard_status_bit = 1'b0;
            st_d.sticky_status_bit = 1'b0;
            if (ctrl.invalid_enable) begin
              wr_d = 1'b0;
              inv_trap_d = 1'b1;
            end
          end else if (add_ovf) begin
            res_d = big[63] ? dfa_pkg::DFA_NMAX : dfa_pkg::DFA_PMAX;
            st_d.overflow_flag = 1'b1;
            st_d.guard_status_bit = 1'b0;
            st_d.sticky_status_bit = 1'b0;
            if (ctrl.overflow_enable) begin
              wr_d = 1'b0;
              ar_trap_d = 1'b1;
            end else st_d.inexact_sticky_flag = 1'b1;
          end else if (add_unf) begin
            res_d = (ctrl.rounding_control_field == dfa_pkg::DFA_RND_MINF) ? 64'h8000_0000_0000_0000 : 64'h0;
            st_d.underflow_flag = 1'b1;
            st_d.guard_status_bit = 1'b0;
            st_d.sticky_status_bit = 1'b0;
            if (ctrl.underflow_enable) begin
              wr_d = 1'b0;
              ar_trap_d = 1'b1;
            end
          end else if (add_g || add_s) begin
            st_d.inexact_sticky_flag = 1'b1;
            if (ctrl.inexact_enable) begin
              rnd_trap_d = 1'b1;
              res_d = {big[63], add_exp[10:0], add_frac};
            end
          end
        end
        dfa_pkg::DFA_OP_CFS: begin
          upd_d = 1'b1;
          st_d.guard_status_bit = 1'b0;
          st_d.sticky_status_bit = 1'b0;
          if (sp_v[30:0] == 31'h0) res_d = {sp_v[31], 63'h0};
          else if (s_exp == dfa_pkg::DFA_SEXP_MAX || s_exp == 8'h00) begin
            st_d.invalid_flag = 1'b1;
            res_d = (s_exp == 8'h00) ? {sp_v[31], 63'h0} : {sp_v[31], dfa_pkg::DFA_PMAX[62:0]};
            if (ctrl.invalid_enable) begin
              wr_d = 1'b0;
              inv_trap_d = 1'b1;
            end
          end else res_d = {sp_v[31], {3'h0, s_exp} + dfa_pkg::DFA_EXP_BIAS - 11'h0_7F, sp_v[22:0], 29'h0};
        end
        dfa_pkg::DFA_OP_CFSF, dfa_pkg::DFA_OP_CFSI: begin
          upd_d = 1'b1;
          st_d.guard_status_bit = 1'b0;
          st_d.sticky_status_bit = 1'b0;
          res_d = (cv_mag == 64'h0) ? 64'h0 : {cv_sign, cv_n[65:55], cv_n[54:3]};
        end
        dfa_pkg::DFA_OP_CFSID: begin
          upd_d = 1'b1;
          st_d.guard_status_bit = cv_n[2];
          st_d.sticky_status_bit = cv_n[1] | cv_n[0];
          res_d = (cv_mag == 64'h0) ? 64'h0 : {cv_sign, dfa_round(cv_n[65:3], cv_sign, cv_n[2], cv_n[1] | cv_n[0],
                                                                  ctrl.rounding_control_field)};
          if (cv_n[2] | cv_n[1] | cv_n[0]) begin
            st_d.inexact_sticky_flag = 1'b1;
            if (ctrl.inexact_enable) begin
              rnd_trap_d = 1'b1;
              res_d = {cv_sign, cv_n[65:3]};
            end
          end
        end
        default: wr_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
      wr_en_q <= 1'b0;
      result_q <= dfa_pkg::DFA_RESULT_RST;
      invalid_trap_q <= 1'b0;
      arith_trap_q <= 1'b0;
      round_trap_q <= 1'b0;
      status_upd_q <= 1'b0;
      status_q <= '0;
    end else begin
      done_q <= issue_valid;
      wr_en_q <= wr_d;
      result_q <= res_d;
      invalid_trap_q <= inv_trap_d;
      arith_trap_q <= ar_trap_d;
      round_trap_q <= rnd_trap_d;
      status_upd_q <= upd_d;
      status_q <= st_d;
    end
  end

  trap_no_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (invalid_trap_q || arith_trap_q) |-> !wr_en_q) else $error("trap with write");
  abs_sign_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    issue_valid && issue_op == dfa_pkg::DFA_OP_ABS |=> !result_q[63] || !wr_en_q) else $error("abs sign set");
  add_inv_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    issue_valid && issue_op == dfa_pkg::DFA_OP_ADD && (a_spec || b_spec) |=> status_q.invalid_flag
    && !status_q.guard_status_bit) else $error("add invalid missed");
  round_trap_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    round_trap_q |-> wr_en_q && status_q.inexact_sticky_flag) else $error("round trap bad");
  cfs_clear_gs_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    issue_valid && issue_op == dfa_pkg::DFA_OP_CFS |=> !status_q.guard_status_bit
    && !status_q.sticky_status_bit) else $error("cfs guard set");
  cfsi_no_exc_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    issue_valid && issue_op == dfa_pkg::DFA_OP_CFSI |=> wr_en_q && !invalid_trap_q) else $error("cfsi trapped");
  done_follow_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_en_q |-> done_q) else $error("write without issue");
  sat_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    issue_valid && issue_op == dfa_pkg::DFA_OP_SAT && sat_ovf && sat_carry
    |=> result_q == $past(second_source_operand)) else $error("sat neg wrong");
endmodule : dfa_datapath

// ==== design/dfa_pkg.sv ====
/*
  constants, operation codes and carrier structs for the float arithmetic and convert datapath.
  assumes a pipeline that issues one operation per cycle and supplies control bits as plain levels.
*/
// Function
// - saturate: ovf&carry neg, ovf pos, else value
// - bit-reversed increment of index under mask
// - absolute value clears sign bit only
// - without detection, plain sign clear allowed
// - abs special operand: invalid, clear guard/sticky
// - add sums both operands into destination
// - add special operands give signed maximum
// - add underflow: +0, or -0 toward minus
// - add special operand: invalid, trap if enabled
// - add overflow/underflow set their flags
// - enabled overflow/underflow traps, no write
// - inexact or masked overflow sets inexact sticky
// - inexact enabled: trap, write truncated, guard/sticky
// - add clears guard/sticky on errors
// - single to double exact, signed zero
// - special single: invalid, max; denormal: zero
// - single convert traps if enabled; clears guard/sticky
// - signed fraction to double, no exceptions
// - signed integer to double, no exceptions
// - 64-bit integer to double rounds, inexact
// - round nearest: increment if guard&(sticky|lsb)
package dfa_pkg;
  typedef enum logic [3:0] {
    DFA_OP_SAT = 4'h0, DFA_OP_BRINC = 4'h1, DFA_OP_ABS = 4'h2, DFA_OP_ADD = 4'h3,
    DFA_OP_CFS = 4'h4, DFA_OP_CFSF = 4'h5, DFA_OP_CFSI = 4'h6, DFA_OP_CFSID = 4'h7
  } dfa_op_t;
  localparam logic [1:0] DFA_RND_NEAR = 2'h0;
  localparam logic [1:0] DFA_RND_ZERO = 2'h1;
  localparam logic [1:0] DFA_RND_PINF = 2'h2;
  localparam logic [1:0] DFA_RND_MINF = 2'h3;
  localparam logic [10:0] DFA_EXP_MAX = 11'h7_FF;
  localparam logic [10:0] DFA_EXP_BIAS = 11'h3_FF;
  localparam logic [10:0] DFA_EXP_FRAC = 11'h3_FF;  // fraction alignment
  localparam logic [10:0] DFA_EXP_INT = 11'h4_1E;   // 1054, integer alignment
  localparam logic [7:0] DFA_SEXP_MAX = 8'hFF;
  localparam logic [63:0] DFA_PMAX = 64'h7FEF_FFFF_FFFF_FFFF;
  localparam logic [63:0] DFA_NMAX = 64'hFFEF_FFFF_FFFF_FFFF;
  localparam logic [63:0] DFA_RESULT_RST = 64'h0000_0000_0000_0000;
  typedef struct packed {
    logic invalid_flag;
    logic overflow_flag;
    logic underflow_flag;
    logic inexact_sticky_flag;
    logic guard_status_bit;
    logic sticky_status_bit;
  } dfa_status_t;
  typedef struct packed {
    logic invalid_enable;
    logic overflow_enable;
    logic underflow_enable;
    logic inexact_enable;
    logic abs_detect_enable;
    logic [1:0] rounding_control_field;
  } dfa_ctrl_t;
endpackage : dfa_pkg

// ==== bench/dfa_rf_model.sv ====
/*
  register file model of the issuing pipeline: keeps the destination register and counts traps.
  assumes the datapath's registered write and trap pulses, sampled on the rising edge.
*/
module dfa_rf_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // results from the datapath
  input wire logic wr_en_q,
  input wire logic [63:0] result_q,
  input wire logic any_trap,
  // what software sees
  output logic [63:0] dest_q,
  output logic [7:0] trap_cnt_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // an invalid or arith trapped op leaves the old destination, so only the write pulse updates it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dest_q <= 64'h0000_0000_0000_0000;
      trap_cnt_q <= 8'h00;
    end else begin
      if (wr_en_q) begin
        dest_q <= result_q;
      end
      if (any_trap) begin
        trap_cnt_q <= trap_cnt_q + 8'h01;
      end
    end
  end
endmodule : dfa_rf_model

// ==== bench/testbench.sv ====
/*
  self-checking bench for the float arithmetic and convert datapath, one task per scenario.
  assumes one op taken per issue_valid cycle and done_q one cycle later.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic issue_valid = 1'b0;
  dfa_pkg::dfa_op_t issue_op = dfa_pkg::DFA_OP_SAT;
  logic [63:0] src_a = 64'h0000_0000_0000_0000;
  logic [63:0] src_b = 64'h0000_0000_0000_0000;
  logic sat_ovf = 1'b0;
  logic sat_carry = 1'b0;
  dfa_pkg::dfa_ctrl_t ctrl = '0;
  logic done_q, wr_en_q, invalid_trap_q, arith_trap_q, round_trap_q, status_upd_q;
  logic [63:0] result_q;
  logic [63:0] dest_q;
  logic [7:0] trap_cnt_q;
  dfa_pkg::dfa_status_t status_q;
  int fail_count = 0;
  int checks_done = 0;
  always #2.5 ref_clk = ~ref_clk;
  dfa_datapath i_dfa_datapath (.ref_clk(ref_clk), .arst_n(arst_n), .issue_valid(issue_valid),
    .issue_op(issue_op), .first_source_operand(src_a), .second_source_operand(src_b),
    .sat_ovf(sat_ovf), .sat_carry(sat_carry), .ctrl(ctrl), .done_q(done_q), .wr_en_q(wr_en_q),
    .result_q(result_q), .invalid_trap_q(invalid_trap_q), .arith_trap_q(arith_trap_q),
    .round_trap_q(round_trap_q), .status_upd_q(status_upd_q), .status_q(status_q));
  dfa_rf_model i_dfa_rf_model (.ref_clk(ref_clk), .arst_n(arst_n), .wr_en_q(wr_en_q),
    .result_q(result_q), .any_trap(invalid_trap_q | arith_trap_q | round_trap_q),
    .dest_q(dest_q), .trap_cnt_q(trap_cnt_q));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // ev = {write, invalid trap, arith trap, round trap}; st = {check, must-set flags, guard, sticky}
  task automatic issue(input dfa_pkg::dfa_op_t op, input logic [63:0] a, input logic [63:0] b,
      input logic [6:0] c, input logic [3:0] ev, input logic [63:0] res, input logic [6:0] st);
    logic [63:0] old_dest;
    logic [7:0] old_traps;
    logic [3:0] seen;
    int n;
    old_dest = dest_q;
    old_traps = trap_cnt_q;
    @(posedge ref_clk);
    issue_valid <= 1'b1;
    issue_op <= op;
    src_a <= a;
    src_b <= b;
    ctrl <= c;
    @(posedge ref_clk);
    issue_valid <= 1'b0;
    n = 0;
    @(negedge ref_clk);
    while (done_q !== 1'b1) begin
      n++;
      if (n > 4) begin
        fail_count++;
        $display("ERROR done_q expected 1 seen timeout");
        summarize();
      end
      @(negedge ref_clk);
    end
    seen = {wr_en_q, invalid_trap_q, arith_trap_q, round_trap_q};
    `CHK("events", ev, seen)
    if (ev[3]) `CHK("result", res, result_q)
    if (st[6]) begin
      `CHK("status_upd", 1'b1, status_upd_q)
      `CHK("flags", st[5:2], status_q[5:2] & st[5:2])
      `CHK("guard_sticky", st[1:0], status_q[1:0])
    end
    @(negedge ref_clk);
    `CHK("dest", ev[3] ? res : old_dest, dest_q)
    `CHK("traps", old_traps + {7'h00, |ev[2:0]}, trap_cnt_q)
  endtask : issue
  task automatic t_sat();
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      sat_ovf <= k[1];
      sat_carry <= k[0];
      issue(dfa_pkg::DFA_OP_SAT, 64'h1111_2222_3333_4444, 64'h9999_AAAA_BBBB_CCCC, 7'h00, 4'h8,
        k[1] ? (k[0] ? 64'h9999_AAAA_BBBB_CCCC : 64'h1111_2222_3333_4444) : 64'h0000_0000_BBBB_CCCC, 7'h00);
    end
    $display("test sat done");
  endtask : t_sat
  task automatic t_brinc();
    // masks as software builds them: three-bit masks at bit offsets 0, 1 and 2
    issue(dfa_pkg::DFA_OP_BRINC, 64'h1234_0000_0000_00F5, 64'h7, 7'h00, 4'h8, 64'h1234_0000_0000_00F3, 7'h00);
    issue(dfa_pkg::DFA_OP_BRINC, 64'hC, 64'hE, 7'h00, 4'h8, 64'h2, 7'h00);
    issue(dfa_pkg::DFA_OP_BRINC, 64'h1C, 64'h1C, 7'h00, 4'h8, 64'h0, 7'h00);
    $display("test brinc done");
  endtask : t_brinc
  task automatic t_abs();
    issue(dfa_pkg::DFA_OP_ABS, 64'hC008_0000_0000_0000, 64'h0, 7'h00, 4'h8, 64'h4008_0000_0000_0000, 7'h00);
    issue(dfa_pkg::DFA_OP_ABS, 64'hFFF0_0000_0000_0000, 64'h0, 7'h44, 4'h4, 64'h0, 7'h60);
    $display("test abs done");
  endtask : t_abs
  task automatic t_add();
    issue(dfa_pkg::DFA_OP_ADD, 64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, 7'h00, 4'h8,
      64'h4000_0000_0000_0000, 7'h40);
    issue(dfa_pkg::DFA_OP_ADD, 64'hFFF8_0000_0000_0000, 64'h7FF0_0000_0000_0000, 7'h00, 4'h8, dfa_pkg::DFA_NMAX, 7'h60);
    issue(dfa_pkg::DFA_OP_ADD, 64'h3FF0_0000_0000_0000, 64'h7FF0_0000_0000_0000, 7'h00, 4'h8, dfa_pkg::DFA_PMAX, 7'h60);
    issue(dfa_pkg::DFA_OP_ADD, 64'h3FF0_0000_0000_0000, 64'h1, 7'h40, 4'h4, 64'h0, 7'h60);
    issue(dfa_pkg::DFA_OP_ADD, dfa_pkg::DFA_PMAX, dfa_pkg::DFA_PMAX, 7'h00, 4'h8, dfa_pkg::DFA_PMAX, 7'h54);
    issue(dfa_pkg::DFA_OP_ADD, dfa_pkg::DFA_PMAX, dfa_pkg::DFA_PMAX, 7'h20, 4'h2, 64'h0, 7'h50);
    for (int r = 0; r < 4; r++) begin
      issue(dfa_pkg::DFA_OP_ADD, 64'h0010_0000_0000_0000, 64'h8010_0000_0000_0001, 7'(r), 4'h8,
        (r == 3) ? 64'h8000_0000_0000_0000 : 64'h0000_0000_0000_0000, 7'h48);
    end
    issue(dfa_pkg::DFA_OP_ADD, 64'h0010_0000_0000_0000, 64'h8010_0000_0000_0001, 7'h10, 4'h2, 64'h0, 7'h48);
    issue(dfa_pkg::DFA_OP_ADD, 64'h3FF0_0000_0000_0000, 64'h3C30_0000_0000_0000, 7'h08, 4'h9,
      64'h3FF0_0000_0000_0000, 7'h45);
    // ties: lsb clear stays, lsb set rounds up, toward zero truncates
    issue(dfa_pkg::DFA_OP_ADD, 64'h3FF0_0000_0000_0000, 64'h3CA0_0000_0000_0000, 7'h00, 4'h8, 64'h3FF0_0000_0000_0000, 7'h00);
    issue(dfa_pkg::DFA_OP_ADD, 64'h3FF0_0000_0000_0001, 64'h3CA0_0000_0000_0000, 7'h00, 4'h8, 64'h3FF0_0000_0000_0002, 7'h00);
    issue(dfa_pkg::DFA_OP_ADD, 64'h3FF0_0000_0000_0001, 64'h3CA0_0000_0000_0000, 7'h01, 4'h8, 64'h3FF0_0000_0000_0001, 7'h00);
    $display("test add done");
  endtask : t_add
  task automatic t_conv();
    // upper source word is junk on purpose: only the low word is read
    issue(dfa_pkg::DFA_OP_CFS, 64'h0, 64'h5555_5555_3F80_0000, 7'h00, 4'h8, 64'h3FF0_0000_0000_0000, 7'h40);
    issue(dfa_pkg::DFA_OP_CFS, 64'h0, 64'h8000_0000, 7'h00, 4'h8, 64'h8000_0000_0000_0000, 7'h40);
    issue(dfa_pkg::DFA_OP_CFS, 64'h0, 64'h7F80_0000, 7'h00, 4'h8, 64'h7FEF_FFFF_FFFF_FFFF, 7'h60);
    issue(dfa_pkg::DFA_OP_CFS, 64'h0, 64'hFFC0_0000, 7'h00, 4'h8, 64'hFFEF_FFFF_FFFF_FFFF, 7'h60);
    issue(dfa_pkg::DFA_OP_CFS, 64'h0, 64'h8000_0001, 7'h00, 4'h8, 64'h8000_0000_0000_0000, 7'h60);
    issue(dfa_pkg::DFA_OP_CFS, 64'h0, 64'h7F80_0000, 7'h40, 4'h4, 64'h0, 7'h60);
    issue(dfa_pkg::DFA_OP_CFSF, 64'h0, 64'h4000_0000, 7'h78, 4'h8, 64'h3FE0_0000_0000_0000, 7'h40);
    issue(dfa_pkg::DFA_OP_CFSF, 64'h0, 64'h8000_0000, 7'h78, 4'h8, 64'hBFF0_0000_0000_0000, 7'h40);
    issue(dfa_pkg::DFA_OP_CFSI, 64'h0, 64'hFFFF_FFFF, 7'h78, 4'h8, 64'hBFF0_0000_0000_0000, 7'h40);
    issue(dfa_pkg::DFA_OP_CFSI, 64'h0, 64'h7FFF_FFFF, 7'h00, 4'h8, 64'h41DF_FFFF_FFC0_0000, 7'h40);
    issue(dfa_pkg::DFA_OP_CFSID, 64'h0, 64'h0020_0000_0000_0001, 7'h00, 4'h8, 64'h4340_0000_0000_0000, 7'h46);
    issue(dfa_pkg::DFA_OP_CFSID, 64'h0, 64'h0020_0000_0000_0003, 7'h00, 4'h8, 64'h4340_0000_0000_0002, 7'h46);
    issue(dfa_pkg::DFA_OP_CFSID, 64'h0, 64'h0020_0000_0000_0003, 7'h08, 4'h9, 64'h4340_0000_0000_0001, 7'h46);
    issue(dfa_pkg::DFA_OP_CFSID, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 7'h00, 4'h8, 64'hBFF0_0000_0000_0000, 7'h40);
    $display("test conv done");
  endtask : t_conv
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_sat();
    t_brinc();
    t_abs();
    t_add();
    t_conv();
    summarize();
  end
endmodule : testbench
